/* src/bcac_backup_check.sv */
// Post-reset integrity check of the battery-backed capacity image.
// Assumes the image holds its contents across reset; this module only reads it.
`timescale 1ns/10ps
`default_nettype none
module bcac_backup_check (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Backed-up image
  input wire bcac_pkg::bcac_backup_t stored,
  // Verdict
  output logic checkDone,
  output logic checkPass
);

  typedef enum logic [1:0] {ChkIdle, ChkRun, ChkDone} bcac_chk_t;
  bcac_chk_t state_q;

  wire logic remCopyOk = (stored.remHiCopy == stored.remCap[15:8]);
  wire logic lrnCopyOk = (stored.lrnHiCopy == stored.lrnCap[15:8]);
  wire logic checkOk = (stored.checkA == bcac_pkg::CHECK_BYTE_A) &&
                       (stored.checkB == bcac_pkg::CHECK_BYTE_B);
  // An unknown image compares false, so a cold start takes the fail path.
  wire logic allOk = remCopyOk && lrnCopyOk && checkOk;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ChkIdle;
      checkDone <= 1'b0;
      checkPass <= 1'b0;
    end else if (clkEn) begin
      checkDone <= 1'b0;
      case (state_q)
        ChkIdle: begin
          state_q <= ChkRun;
        end
        ChkRun: begin
          checkPass <= allOk ? 1'b1 : 1'b0;
          checkDone <= 1'b1;
          state_q <= ChkDone;
        end
        default: begin
          state_q <= ChkDone;
        end
      endcase
    end
  end

endmodule : bcac_backup_check
`default_nettype wire

/* src/bcac_core.sv */
// Charge accounting core: counts charge, keeps capacity, reports results.
// Assumes measurements arrive on clk; the host line is an unsynchronised pin.
`timescale 1ns/10ps
`default_nettype none
module bcac_core #(
  parameter int SleepHoldCycles = bcac_pkg::SLEEP_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,

  // Integrator
  input wire bcac_pkg::bcac_count_t countIn,

  // Nonvolatile configuration
  input wire logic [7:0] filterThreshold,
  input wire logic [15:0] nvLearnedCapacity,
  input wire logic [15:0] edv1Threshold,
  input wire logic [15:0] edvfThreshold,
  input wire logic [15:0] coldTemp,
  input wire logic [15:0] hotTemp,

  // Measurements
  input wire logic [15:0] voltRaw,
  input wire logic [15:0] voltOffset,
  input wire logic voltValid,
  input wire logic [15:0] tempIn,
  input wire logic tempValid,
  input wire logic selfDischargeTick,

  // Host side
  input wire logic hostLineIn,
  input wire logic signed [15:0] atRate,
  input wire logic atRateStrobe,

  // Charge and capacity
  output logic signed [31:0] netCharge,
  output logic [15:0] remainingCapacity,
  output logic [15:0] learnedCapacity,
  output logic [15:0] availableCapacity,
  output logic capacityInaccurate,
  output logic checkDone,

  // Voltage and temperature
  output logic [15:0] voltage,
  output logic [15:0] temperature,
  output logic edv1Reached,
  output logic emptyFlag,

  // Time to empty
  output logic [15:0] timeToEmpty,
  output logic emptyTimeValid,

  // Power state
  output logic sleepMode
);

  localparam int SleepW = $clog2(SleepHoldCycles + 1);
  localparam logic [SleepW-1:0] SleepLast = SleepW'(SleepHoldCycles);

  // Filter

  logic accepted;
  logic dischargeDir;

  bcac_mag_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .countIn(countIn),
    .threshold(filterThreshold),
    .accepted(accepted),
    .discharge(dischargeDir)
  );

  // Backed-up capacity image

  // This image is the battery-backed RAM, so reset leaves it alone.
  bcac_pkg::bcac_backup_t backup_q;
  logic chkDone;
  logic chkPass;

  bcac_backup_check u_check (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .stored(backup_q),
    .checkDone(chkDone),
    .checkPass(chkPass)
  );

  // Capacity state

  logic ready_q;
  logic [15:0] rem_q;
  logic [15:0] lrn_q;
  logic inacc_q;
  logic chargeSkip_q;
  logic signed [31:0] net_q;

  logic cold_q;
  logic hot_q;

  // Counts are accepted only once the image has been judged.
  wire logic countOk = accepted && ready_q;
  wire logic takeDis = countOk && dischargeDir;
  // A cold cell takes only every other charge count.
  wire logic takeChg = countOk && !dischargeDir && !(cold_q && chargeSkip_q);

  wire logic [15:0] capInc = (rem_q < lrn_q) ? 16'(rem_q + 16'h0001) : lrn_q;
  wire logic [15:0] capCount = takeDis ? bcac_pkg::satSub(rem_q, 16'h0001) :
                               takeChg ? capInc : rem_q;
  wire logic [15:0] selfLoss = hot_q ? 16'h0002 : 16'h0001;
  wire logic selfOn = selfDischargeTick && ready_q;
  wire logic [15:0] capNext = selfOn ? bcac_pkg::satSub(capCount, selfLoss) : capCount;

  wire logic signed [31:0] netStep = takeDis ? -32'sd1 : 32'sd1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
      rem_q <= bcac_pkg::CAP_RST;
      lrn_q <= bcac_pkg::CAP_RST;
      inacc_q <= 1'b0;
    end else if (clkEn) begin
      if (chkDone) begin
        ready_q <= 1'b1;
        if (chkPass) begin
          rem_q <= backup_q.remCap;
          lrn_q <= backup_q.lrnCap;
          inacc_q <= backup_q.inaccurate;
        end else begin
          rem_q <= bcac_pkg::CAP_RST;
          lrn_q <= nvLearnedCapacity;
          inacc_q <= 1'b1;
        end
      end else if (ready_q) begin
        rem_q <= capNext;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      net_q <= bcac_pkg::NET_RST;
      chargeSkip_q <= 1'b0;
    end else if (clkEn) begin
      if (takeDis || takeChg) begin
        net_q <= net_q + netStep;
      end
      if (countOk && !dischargeDir) begin
        chargeSkip_q <= !chargeSkip_q;
      end
    end
  end

  // Keep the image current, with redundant high bytes and check bytes.
  always_ff @(posedge clk) begin
    if (!sys_rst && clkEn && ready_q) begin
      backup_q.remCap <= rem_q;
      backup_q.lrnCap <= lrn_q;
      backup_q.remHiCopy <= rem_q[15:8];
      backup_q.lrnHiCopy <= lrn_q[15:8];
      backup_q.checkA <= bcac_pkg::CHECK_BYTE_A;
      backup_q.checkB <= bcac_pkg::CHECK_BYTE_B;
      backup_q.inaccurate <= inacc_q;
    end
  end

  // Temperature and compensation

  logic [15:0] temp_q;
  logic [15:0] avail_q;

  wire logic [15:0] coldLoss = {3'b000, rem_q[15:3]};
  wire logic [15:0] availNext = cold_q ? bcac_pkg::satSub(rem_q, coldLoss) : rem_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_q <= bcac_pkg::MEAS_RST;
      cold_q <= 1'b0;
      hot_q <= 1'b0;
      avail_q <= bcac_pkg::CAP_RST;
    end else if (clkEn) begin
      if (tempValid) begin
        temp_q <= tempIn;
        cold_q <= (tempIn < coldTemp);
        hot_q <= (tempIn > hotTemp);
      end
      avail_q <= availNext;
    end
  end

  // Voltage

  logic [15:0] volt_q;
  logic edv1_q;
  logic edvf_q;

  wire logic [15:0] voltCorr = bcac_pkg::satSub(voltRaw, voltOffset);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      volt_q <= bcac_pkg::MEAS_RST;
      edv1_q <= 1'b0;
      edvf_q <= 1'b0;
    end else if (clkEn && voltValid) begin
      volt_q <= voltCorr;
      edv1_q <= (voltCorr <= edv1Threshold);
      edvf_q <= (voltCorr <= edvfThreshold);
    end
  end

  // Time to empty at the host rate

  // A serial divider keeps area small; an answer takes 25 cycles.
  logic divBusy_q;
  logic [4:0] divCnt_q;
  logic [23:0] divQ_q;
  logic [16:0] divR_q;
  logic [15:0] divisor_q;
  logic [15:0] emptyTime_q;
  logic emptyTimeValid_q;

  wire logic rateDrains = atRate[15];
  wire logic [23:0] dividend = 24'(avail_q) * 24'(bcac_pkg::MIN_PER_HOUR);
  wire logic [16:0] remShift = {divR_q[15:0], divQ_q[23]};
  wire logic remGe = (remShift >= {1'b0, divisor_q});
  wire logic [16:0] remNext = remGe ? 17'(remShift - {1'b0, divisor_q}) : remShift;
  wire logic [23:0] quotNext = {divQ_q[22:0], remGe};
  wire logic quotBig = (quotNext[23:16] != 8'h00);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divBusy_q <= 1'b0;
      divCnt_q <= 5'h00;
      divQ_q <= 24'h00_0000;
      divR_q <= 17'h0_0000;
      divisor_q <= 16'h0000;
      emptyTime_q <= bcac_pkg::EMPTY_TIME_NONE;
      emptyTimeValid_q <= 1'b0;
    end else if (clkEn) begin
      emptyTimeValid_q <= 1'b0;
      if (atRateStrobe && !divBusy_q) begin
        if (rateDrains) begin
          divBusy_q <= 1'b1;
          divCnt_q <= 5'h00;
          divQ_q <= dividend;
          divR_q <= 17'h0_0000;
          divisor_q <= bcac_pkg::abs16(atRate);
        end else begin
          emptyTime_q <= bcac_pkg::EMPTY_TIME_NONE;
          emptyTimeValid_q <= 1'b1;
        end
      end else if (divBusy_q) begin
        divQ_q <= quotNext;
        divR_q <= remNext;
        divCnt_q <= 5'(divCnt_q + 5'h01);
        if (divCnt_q == 5'h17) begin
          divBusy_q <= 1'b0;
          emptyTime_q <= quotBig ? bcac_pkg::EMPTY_TIME_NONE : quotNext[15:0];
          emptyTimeValid_q <= 1'b1;
        end
      end
    end
  end

  // Sleep detection on the host line

  logic hostMeta_q;
  logic hostSync_q;
  logic [SleepW-1:0] lowCnt_q;
  logic sleep_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hostMeta_q <= 1'b1;
      hostSync_q <= 1'b1;
      lowCnt_q <= '0;
      sleep_q <= 1'b0;
    end else if (clkEn) begin
      hostMeta_q <= hostLineIn;
      hostSync_q <= hostMeta_q;
      if (hostSync_q) begin
        lowCnt_q <= '0;
        sleep_q <= 1'b0;
      end else if (lowCnt_q == SleepLast) begin
        sleep_q <= 1'b1;
      end else begin
        lowCnt_q <= SleepW'(lowCnt_q + 1'b1);
      end
    end
  end

  // Outputs

  assign netCharge = net_q;
  assign remainingCapacity = rem_q;
  assign learnedCapacity = lrn_q;
  assign availableCapacity = avail_q;
  assign capacityInaccurate = inacc_q;
  assign checkDone = ready_q;
  assign voltage = volt_q;
  assign temperature = temp_q;
  assign edv1Reached = edv1_q;
  assign emptyFlag = edvf_q;
  assign timeToEmpty = emptyTime_q;
  assign emptyTimeValid = emptyTimeValid_q;
  assign sleepMode = sleep_q;

endmodule : bcac_core
`default_nettype wire

/* src/bcac_mag_filter.sv */
// Magnitude filter in front of the charge accumulator.
// Assumes integrator samples arrive on the core clock in 3 uV steps.
`timescale 1ns/10ps
`default_nettype none
module bcac_mag_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Integrator sample and threshold
  input wire bcac_pkg::bcac_count_t countIn,
  input wire logic [7:0] threshold,
  // Filtered count
  output logic accepted,
  output logic discharge
);

  wire logic [15:0] magnitude = bcac_pkg::abs16(countIn.sample);
  wire logic [16:0] limit = 17'(threshold * bcac_pkg::THRESH_SCALE);
  wire logic filterOff = (threshold == 8'h00);
  wire logic passes = filterOff || ({1'b0, magnitude} >= limit);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accepted <= 1'b0;
      discharge <= 1'b0;
    end else if (clkEn) begin
      accepted <= countIn.valid && passes;
      discharge <= countIn.sample[15];
    end
  end

endmodule : bcac_mag_filter
`default_nettype wire

/* src/bcac_pkg.sv */
// Constants, types and helpers shared by the charge accounting core.
// Assumes one 250 MHz clock, synchronous reset and no register bus.
// Overview of operation
// - Accumulate every accepted integrator count into a running net charge total, except every other charge count while cold.
// - Ignore integrator counts whose magnitude lies below the filter threshold.
// - Filter threshold comes from nonvolatile setup, one step per 6 uV.
// - A zero threshold disables the filter so every count is taken.
// - Enter sleep once the host line has been held low for 100 us.
// - Keep redundant copies of capacity high bytes in backed-up storage.
// - After reset compare copies with primaries and verify two check bytes.
// - On a clean check keep both capacities and the inaccurate flag.
// - On a failed check clear remaining, reload learned, set inaccurate flag.
// - Reset initializes all state except the protected capacity values.
// - Available capacity counts in units of 3 over sense milliohms mAh.
// - Host gives an at-rate current; device reports time-to-empty in minutes.
// - Report offset-corrected voltage and compare it with end-of-discharge thresholds.
// - Temperature steers charge, discharge and self-discharge compensation.
package bcac_pkg;

  localparam int CLK_MHZ = 250;
  localparam int SLEEP_HOLD_US = 100;
  localparam int SLEEP_HOLD_CYC = SLEEP_HOLD_US * CLK_MHZ;

  localparam int THRESH_STEP_UV = 6;
  localparam int SAMPLE_LSB_UV = 3;
  localparam int THRESH_SCALE = THRESH_STEP_UV / SAMPLE_LSB_UV;

  // One capacity count is 3 uVh, which is 3 mAh divided by the sense milliohms.
  localparam int CAP_LSB_UVH = 3;
  localparam int MIN_PER_HOUR = 60;

  localparam logic [7:0] CHECK_BYTE_A = 8'h5a;
  localparam logic [7:0] CHECK_BYTE_B = 8'hc3;
  localparam logic [15:0] EMPTY_TIME_NONE = 16'hffff;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] MEAS_RST = 16'h0000;
  localparam logic [31:0] NET_RST = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic signed [15:0] sample;
  } bcac_count_t;

  typedef struct packed {
    logic [15:0] remCap;
    logic [15:0] lrnCap;
    logic [7:0] remHiCopy;
    logic [7:0] lrnHiCopy;
    logic [7:0] checkA;
    logic [7:0] checkB;
    logic inaccurate;
  } bcac_backup_t;

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : abs16

  function automatic logic [15:0] satSub(input logic [15:0] a, input logic [15:0] b);
    satSub = (a > b) ? 16'(a - b) : 16'h0000;
  endfunction : satSub

endpackage : bcac_pkg

/* verification/bcac_core_props.sv */
// Port-level checker for the charge accounting core.
// Bound into every core instance; assumes clkEn high while traffic runs.
`timescale 1ns/10ps
`default_nettype none
module bcac_core_props #(
  parameter int SleepHoldCycles = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Stimulus
  input wire bcac_pkg::bcac_count_t countIn,
  input wire logic [7:0] filterThreshold,
  input wire logic [15:0] nvLearnedCapacity,
  input wire logic [15:0] voltRaw,
  input wire logic [15:0] voltOffset,
  input wire logic voltValid,
  input wire logic hostLineIn,
  input wire logic signed [15:0] atRate,
  input wire logic atRateStrobe,
  // Results
  input wire logic signed [31:0] netCharge,
  input wire logic [15:0] remainingCapacity,
  input wire logic [15:0] learnedCapacity,
  input wire logic capacityInaccurate,
  input wire logic checkDone,
  input wire logic [15:0] voltage,
  input wire logic [15:0] timeToEmpty,
  input wire logic emptyTimeValid,
  input wire logic sleepMode
);
  logic [15:0] mag;
  logic pass;
  logic [15:0] lowCnt_q;
  logic [15:0] savedRem_q;
  logic [15:0] savedLmd_q;
  logic savedInacc_q;
  assign mag = countIn.sample[15] ? 16'(-countIn.sample) : 16'(countIn.sample);
  assign pass = (filterThreshold == 8'h00) || (mag >= {7'h00, filterThreshold, 1'b0});
  always_ff @(posedge clk) begin
    if (sys_rst || hostLineIn) lowCnt_q <= 16'h0000;
    else if (lowCnt_q != 16'hffff) lowCnt_q <= lowCnt_q + 16'h0001;
  end
  // Last values seen while running, i.e. what the backed-up image should hold.
  always_ff @(posedge clk) begin
    if (checkDone) begin
      savedRem_q <= remainingCapacity;
      savedLmd_q <= learnedCapacity;
      savedInacc_q <= capacityInaccurate;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_filter;
    clkEn && checkDone && countIn.valid && !pass |-> ##2 $stable(netCharge);
  endproperty
  a_filter: assert property (p_filter)
    else $error("small count reached the total");
  property p_accept;
    clkEn && checkDone && countIn.valid && pass && countIn.sample[15]
      |-> ##2 netCharge == $past(netCharge) - 32'sd1;
  endproperty
  a_accept: assert property (p_accept)
    else $error("discharge count not accumulated");
  property p_ckdone;
    $fell(sys_rst) |-> !checkDone ##[1:4] checkDone;
  endproperty
  a_ckdone: assert property (p_ckdone)
    else $error("image check did not finish");
  property p_restore;
    $rose(checkDone) |-> (remainingCapacity == savedRem_q && learnedCapacity == savedLmd_q
      && capacityInaccurate == savedInacc_q) || (remainingCapacity == 16'h0000
      && learnedCapacity == nvLearnedCapacity && capacityInaccurate);
  endproperty
  a_restore: assert property (p_restore)
    else $error("capacity image handled wrongly");
  property p_rst;
    $fell(sys_rst) |-> netCharge == 32'sh0 && timeToEmpty == 16'hffff && !emptyTimeValid
      && !sleepMode;
  endproperty
  a_rst: assert property (p_rst)
    else $error("state not initialised by reset");
  property p_volt;
    voltValid |=> voltage == (($past(voltRaw) > $past(voltOffset)) ?
      16'($past(voltRaw) - $past(voltOffset)) : 16'h0000);
  endproperty
  a_volt: assert property (p_volt)
    else $error("corrected voltage wrong");
  property p_atchg;
    atRateStrobe && !atRate[15] |=> emptyTimeValid && timeToEmpty == 16'hffff;
  endproperty
  a_atchg: assert property (p_atchg)
    else $error("charge rate answer wrong");
  property p_atdis;
    atRateStrobe && atRate[15] |-> ##25 emptyTimeValid;
  endproperty
  a_atdis: assert property (p_atdis)
    else $error("discharge rate answer late");
  property p_sleep;
    lowCnt_q == 16'(SleepHoldCycles + 5) |-> sleepMode;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("no sleep with line held low");
  c_accept: cover property (countIn.valid && pass && checkDone);
  c_sleep: cover property ($rose(sleepMode));
  c_atdis: cover property (atRateStrobe && atRate[15]);
endmodule : bcac_core_props
bind bcac_core bcac_core_props #(.SleepHoldCycles(SleepHoldCycles)) u_props (.*);
`default_nettype wire

/* verification/bcac_host_model.sv */
// Host processor model: single-wire line level and at-rate requests.
// Driven by task calls from the bench; acts just after rising edges.
`timescale 1ns/10ps
`default_nettype none
module bcac_host_model (
  // Clock
  input wire logic clk,
  // Host side of the core
  output logic hostLineIn,
  output logic signed [15:0] atRate,
  output logic atRateStrobe
);
  logic powered;
  // The line has a pull-down, so an unpowered host leaves it at 0.
  assign hostLineIn = powered;
  initial begin
    powered = 1'b1;
    atRate = 16'sh0;
    atRateStrobe = 1'b0;
  end
  task automatic setPower(input logic on);
    @(posedge clk);
    powered <= on;
  endtask : setPower
  // The rate shows its inverse once the strobe drops, so a late read fails.
  task automatic askRate(input logic signed [15:0] rate);
    @(posedge clk);
    atRate <= rate;
    atRateStrobe <= 1'b1;
    @(posedge clk);
    atRateStrobe <= 1'b0;
    atRate <= ~rate;
  endtask : askRate
endmodule : bcac_host_model
`default_nettype wire

/* verification/bcac_tb.sv */
// Self-checking bench for the charge accounting core with a host model.
// Assumes a 250 MHz clock and a short sleep hold for simulation.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int Hold = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  bcac_pkg::bcac_count_t countIn = '0;
  logic [7:0] filterThreshold = 8'h00;
  logic [15:0] nvLearnedCapacity = 16'h0400;
  logic [15:0] edv1Threshold = 16'h0d00;
  logic [15:0] edvfThreshold = 16'h0c00;
  logic [15:0] coldTemp = 16'h0100;
  logic [15:0] hotTemp = 16'h0200;
  logic [15:0] voltRaw = 16'h0000;
  logic [15:0] voltOffset = 16'h0000;
  logic voltValid = 1'b0;
  logic [15:0] tempIn = 16'h0180;
  logic tempValid = 1'b0;
  logic selfDischargeTick = 1'b0;
  logic hostLineIn;
  logic signed [15:0] atRate;
  logic atRateStrobe;
  logic signed [31:0] netCharge;
  logic [15:0] remainingCapacity, learnedCapacity, availableCapacity, voltage;
  logic [15:0] temperature, timeToEmpty;
  logic capacityInaccurate, checkDone, edv1Reached, emptyFlag, emptyTimeValid, sleepMode;
  int err_count = 0;
  int n_checks = 0;
  integer seed = 32'h3ef24e56;
  int expNet;
  logic [15:0] expRem;
  logic signed [31:0] lastNet;
  logic signed [31:0] qNet[$];
  logic [15:0] qTime[$];
  bcac_core #(.SleepHoldCycles(Hold)) dut (.*);
  bcac_host_model host (.*);
  always #2 clk = ~clk;
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task automatic doReset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 20 && checkDone !== 1'b1; i++) @(posedge clk);
    if (checkDone !== 1'b1) begin
      err_count++;
      summarize();
    end
    cyc(1);
  endtask : doReset
  task automatic sendCount(input logic signed [15:0] s);
    logic [15:0] m;
    m = s[15] ? 16'(-s) : 16'(s);
    @(posedge clk);
    countIn <= {1'b1, s};
    if (filterThreshold == 8'h00 || m >= 16'(filterThreshold) * 16'd2) begin
      expNet += s[15] ? -1 : 1;
      qNet.push_back(32'(expNet));
      if (s[15] && expRem != 16'h0000) expRem--;
      else if (!s[15] && expRem != nvLearnedCapacity) expRem++;
    end
  endtask : sendCount
  task automatic measure(input logic [15:0] raw, input logic [15:0] off);
    logic [15:0] v;
    v = (raw > off) ? 16'(raw - off) : 16'h0000;
    @(posedge clk);
    voltRaw <= raw;
    voltOffset <= off;
    voltValid <= 1'b1;
    @(posedge clk);
    voltValid <= 1'b0;
    cyc(1);
    check(voltage === v, "voltage");
    check(edv1Reached === (v <= edv1Threshold) && emptyFlag === (v <= edvfThreshold), "edv");
  endtask : measure
  // Expected result is queued before the request so the monitor can match it.
  task automatic askTime(input logic signed [15:0] r);
    int q;
    q = r[15] ? (int'(expRem) * 60) / (-int'(r)) : 65535;
    qTime.push_back((q > 65535) ? 16'hffff : 16'(q));
    host.askRate(r);
    repeat (30) @(posedge clk);
  endtask : askTime
  always @(negedge clk) begin
    if (sys_rst) lastNet = 32'sh0;
    else begin
      if (netCharge !== lastNet) begin
        check(qNet.size() > 0 && netCharge === qNet.pop_front(), "net charge");
        lastNet = netCharge;
      end
      if (emptyTimeValid === 1'b1) check(qTime.size() > 0 && timeToEmpty === qTime.pop_front(), "time to empty");
    end
  end
  initial begin
    logic [7:0] thr[3];
    logic signed [15:0] rates[4];
    thr = '{8'h00, 8'h04, 8'h0a};
    rates = '{16'sd5, -16'sd600, 16'sd0, -16'sd7};
    doReset();
    check(remainingCapacity === 16'h0000 && learnedCapacity === nvLearnedCapacity && capacityInaccurate === 1'b1, "fail path");
    expNet = 0;
    expRem = 16'h0000;
    repeat (40) sendCount(16'sd9);
    foreach (thr[t]) begin
      @(posedge clk);
      countIn <= '0;
      filterThreshold <= thr[t];
      repeat (40) sendCount(16'($random(seed) % 20));
    end
    @(posedge clk);
    countIn <= '0;
    cyc(4);
    check(remainingCapacity === expRem && availableCapacity === expRem, "capacity");
    foreach (rates[i]) askTime(rates[i]);
    measure(16'h0e10, 16'h0010);
    measure(16'h0c90, 16'h0010);
    measure(16'h0005, 16'h0010);
    host.setPower(1'b0);
    repeat (4) @(posedge clk);
    host.setPower(1'b1);
    cyc(Hold + 8);
    check(sleepMode === 1'b0, "short low");
    host.setPower(1'b0);
    cyc(Hold + 8);
    check(sleepMode === 1'b1, "sleep");
    host.setPower(1'b1);
    cyc(6);
    check(sleepMode === 1'b0, "wake");
    @(posedge clk);
    tempIn <= 16'h0080;
    tempValid <= 1'b1;
    @(posedge clk);
    tempValid <= 1'b0;
    selfDischargeTick <= 1'b1;
    if (expRem != 16'h0000) expRem--;
    @(posedge clk);
    selfDischargeTick <= 1'b0;
    cyc(4);
    check(remainingCapacity === expRem, "self discharge");
    check(temperature === 16'h0080, "temperature");
    check(availableCapacity === 16'(expRem - expRem / 8), "cold derate");
    for (int i = 0; i < 50 && qNet.size() + qTime.size() > 0; i++) @(posedge clk);
    check(qNet.size() + qTime.size() == 0, "results missing");
    expNet = 0;
    doReset();
    check(remainingCapacity === expRem && learnedCapacity === nvLearnedCapacity && capacityInaccurate === 1'b1, "kept");
    check(netCharge === 32'sh0 && timeToEmpty === 16'hffff, "reinit");
    summarize();
  end
endmodule : testbench
`default_nettype wire
